// File: rtl/ifd_top.sv
// IF back end: mixer, three decimation stages, gain, serial sample output
//
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
module ifd_top (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // Modulator stream, one sample per clock
    input wire logic signed [ifd_pkg::MOD_W-1:0] mod_data_i,
    input wire logic adc_clip_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    // Analog gain stage attenuation
    output logic [3:0] vga_atten_o,
    // Sample serial output
    output logic so_data_o,
    output logic so_frame_o
);
    import ifd_pkg::*;

    ifd_ctrl_s ctrl_q;
    logic [4:0] dec2_q;
    logic [7:0] gain_q;
    logic [23:0] ref_q;
    logic [23:0] rssi_q;
    logic [3:0] atten_q;
    logic [3:0] vga_atten_q;
    logic clip_q;
    logic [7:0] ovr_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [31:0] rdata_w;
    logic [3:0] dgain_w;
    ifd_so_e so_st_q;

    // APB decode; one wait state so every answer comes from a flop
    wire apb_acc_w = psel_i && penable_i && !pready_q;
    wire apb_wr_w = psel_i && penable_i && pready_q && pwrite_i;
    wire hit_ctrl_w = (paddr_i == ADDR_CTRL);
    wire hit_dec2_w = (paddr_i == ADDR_DEC2);
    wire hit_gain_w = (paddr_i == ADDR_GAIN);
    wire hit_ref_w = (paddr_i == ADDR_REF);
    wire hit_stat_w = (paddr_i == ADDR_STAT);
    wire hit_rssi_w = (paddr_i == ADDR_RSSI);
    wire hit_any_w = hit_ctrl_w | hit_dec2_w | hit_gain_w | hit_ref_w | hit_stat_w | hit_rssi_w;
    wire [4:0] dec2_wr_w = (pwdata_i[4:0] < STG2_MIN) ? STG2_MIN :
                           (pwdata_i[4:0] > STG2_MAX) ? STG2_MAX : pwdata_i[4:0];
    wire [3:0] att_wr_w = (pwdata_i[3:0] > ATTEN_MAX) ? ATTEN_MAX : pwdata_i[3:0];
    wire [31:0] stat_w = 32'(atten_q) | (32'(dgain_w) << STAT_DG_LSB)
                       | (32'(ovr_q) << STAT_OVR_LSB)
                       | (32'(so_st_q == SO_SHIFT) << STAT_BUSY_BIT);
    assign rdata_w = hit_ctrl_w ? 32'(ctrl_q) : hit_dec2_w ? 32'(dec2_q) :
                     hit_gain_w ? 32'(gain_q) : hit_ref_w ? 32'(ref_q) :
                     hit_stat_w ? stat_w : hit_rssi_w ? 32'(rssi_q) : 32'h00000000;

    // APB answer; writes land on the edge the master sees pready
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= apb_acc_w;
            pslverr_q <= apb_acc_w && !hit_any_w;
            prdata_q <= (apb_acc_w && !pwrite_i) ? rdata_w : 32'h00000000;
        end
    end

    // Configuration registers
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= ifd_ctrl_s'(CTRL_RST);
            dec2_q <= DEC2_RST;
            gain_q <= GAIN_RST;
            ref_q <= REF_RST;
        end else if (apb_wr_w) begin
            if (hit_ctrl_w) ctrl_q <= ifd_ctrl_s'(pwdata_i[5:0]);
            if (hit_dec2_w) dec2_q <= dec2_wr_w;
            if (hit_gain_w) gain_q <= {pwdata_i[7:GAIN_DIG_LSB], att_wr_w};
            if (hit_ref_w) ref_q <= pwdata_i[23:0];
        end
    end

    // Carrier phase and mixer; the carrier is the clock divided by eight
    logic [2:0] phase_q;
    logic mix_vld_q;
    logic signed [SMP_W-1:0] mix_q [2];
    wire signed [7:0] cos_w = mix_coef(phase_q);
    wire signed [7:0] sin_w = mix_coef(phase_q + 3'h6);
    wire signed [11:0] mix_i_w = 12'(mod_data_i) * 12'(cos_w); // Widen first, 8 bits would wrap
    wire signed [11:0] mix_q_w = -(12'(mod_data_i) * 12'(sin_w));
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_q <= 3'h0;
            mix_vld_q <= 1'b0;
            mix_q[0] <= '0;
            mix_q[1] <= '0;
        end else begin
            phase_q <= phase_q + 3'h1;
            mix_vld_q <= ctrl_q.run;
            mix_q[0] <= SMP_W'(mix_i_w);
            mix_q[1] <= SMP_W'(mix_q_w);
        end
    end

    // Two comb stages per channel
    logic signed [SMP_W-1:0] s1_w [2];
    logic signed [SMP_W-1:0] s2_w [2];
    logic [1:0] s1_vld_w;
    logic [1:0] s2_vld_w;
    for (genvar c = 0; c < 2; c++) begin : g_ch
        ifd_cic4 u_stg1 (
            .clk_i(sys_clk_i),
            .rst_n_i(rst_n_i),
            .in_vld_i(mix_vld_q),
            .in_i(mix_q[c]),
            .ratio_i(STG1_RATIO),
            .shift_i(STG1_SHIFT),
            .out_vld_o(s1_vld_w[c]),
            .out_o(s1_w[c])
        );
        ifd_cic4 u_stg2 (
            .clk_i(sys_clk_i),
            .rst_n_i(rst_n_i),
            .in_vld_i(s1_vld_w[c]),
            .in_i(s1_w[c]),
            .ratio_i(dec2_q),
            .shift_i(cic_shift(dec2_q)),
            .out_vld_o(s2_vld_w[c]),
            .out_o(s2_w[c])
        );
    end
    wire s1_vld = &s1_vld_w;
    wire s2_vld = &s2_vld_w;

    // Third stage: boxcar average over 4 or 5; 1/5 uses 51/256
    function automatic logic signed [SMP_W-1:0] s3_scale(input logic signed [26:0] s,
                                                        input logic five);
        logic signed [33:0] p;
        p = 34'(s) * 34'(signed'({1'b0, STG3_MUL5}));
        return five ? SMP_W'(p >>> STG3_SHR5) : SMP_W'(s >>> STG3_SHR4);
    endfunction : s3_scale

    logic [2:0] cnt3_q;
    logic signed [26:0] acc3_q [2];
    ifd_iq_s s3_q;
    logic s3_vld_q;
    wire [2:0] last3_w = ctrl_q.r3_five ? STG3_LAST5 : STG3_LAST4;
    wire s3_dump_w = s2_vld && (cnt3_q >= last3_w);
    wire signed [26:0] sum_i_w = acc3_q[0] + 27'(s2_w[0]);
    wire signed [26:0] sum_q_w = acc3_q[1] + 27'(s2_w[1]);
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt3_q <= 3'h0;
            acc3_q[0] <= '0;
            acc3_q[1] <= '0;
            s3_q <= '0;
            s3_vld_q <= 1'b0;
        end else begin
            s3_vld_q <= s3_dump_w;
            if (s2_vld) begin
                cnt3_q <= s3_dump_w ? 3'h0 : cnt3_q + 3'h1;
                acc3_q[0] <= s3_dump_w ? 27'sh0 : sum_i_w;
                acc3_q[1] <= s3_dump_w ? 27'sh0 : sum_q_w;
            end
            if (s3_dump_w) begin
                s3_q.i <= s3_scale(sum_i_w, ctrl_q.r3_five);
                s3_q.q <= s3_scale(sum_q_w, ctrl_q.r3_five);
            end
        end
    end

    // Digital gain: manual value, or manual plus one shift per 6 dB of attenuation
    wire [1:0] att_steps_w = (atten_q >= ATTEN_MAX) ? 2'h2 :
                             (atten_q >= ATTEN_STEP) ? 2'h1 : 2'h0;
    wire [4:0] auto_dg_w = 5'(gain_q[7:GAIN_DIG_LSB]) + 5'(att_steps_w);
    assign dgain_w = !ctrl_q.agc_en ? gain_q[7:GAIN_DIG_LSB] :
                     (auto_dg_w > 5'(DGAIN_MAX)) ? DGAIN_MAX : auto_dg_w[3:0];
    ifd_iq_s out_q;
    logic out_vld_q;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_q <= '0;
            out_vld_q <= 1'b0;
        end else begin
            out_vld_q <= s3_vld_q;
            if (s3_vld_q) out_q <= '{sat_shl(s3_q.i, dgain_w), sat_shl(s3_q.q, dgain_w)};
        end
    end

    // Level estimate taken before digital gain, tracks the ADC level
    wire [24:0] level_w = 25'(mag(s3_q.i)) + 25'(mag(s3_q.q));
    wire [23:0] rssi_d = rssi_q - (rssi_q >> RSSI_SHR) + 24'(level_w >> (RSSI_SHR + 1));
    wire up_w = clip_q || (rssi_q > ref_q);
    wire [3:0] atten_d = (up_w && atten_q < ATTEN_MAX) ? atten_q + 4'h1 :
                         (!up_w && rssi_q < ref_q && atten_q != 4'h0) ? atten_q - 4'h1 : atten_q;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rssi_q <= 24'h000000;
            atten_q <= 4'h0;
            clip_q <= 1'b0;
            vga_atten_q <= 4'h0;
        end else begin
            // A clip in the update cycle survives to the next window
            clip_q <= adc_clip_i || (clip_q && !s3_vld_q);
            if (s3_vld_q) rssi_q <= rssi_d;
            if (s3_vld_q && ctrl_q.agc_en) atten_q <= atten_d;
            vga_atten_q <= ctrl_q.agc_en ? atten_q : gain_q[3:0];
        end
    end

    // Frame build: I, Q, then attenuation and/or RSSI words, MSB first
    wire [23:0] attn_word_w = {vga_atten_q, dgain_w, 16'h0000};
    wire [23:0] x_word_w = ctrl_q.attn_en ? attn_word_w : rssi_q;
    wire [FRM_W-1:0] frame_w = ctrl_q.word16 ?
        {out_q.i[23:8], out_q.q[23:8], x_word_w[23:8], rssi_q[23:8], 32'h00000000} :
        {out_q.i, out_q.q, x_word_w, rssi_q};
    wire [2:0] words_w = 3'h2 + 3'(ctrl_q.attn_en) + 3'(ctrl_q.rssi_en);
    wire [6:0] bits_w = 7'(words_w * (ctrl_q.word16 ? 7'h10 : 7'h18));
    wire so_start_w = out_vld_q && (so_st_q == SO_IDLE);

    logic [FRM_W-1:0] so_sh_q;
    logic [6:0] so_left_q;
    logic so_data_q;
    logic so_frame_q;
    ifd_so_e so_st_d;
    always_comb begin
        so_st_d = so_st_q;
        case (so_st_q)
            SO_IDLE: if (so_start_w) so_st_d = SO_SHIFT;
            SO_SHIFT: if (so_left_q == 7'h00) so_st_d = SO_IDLE;
            default: so_st_d = SO_IDLE;
        endcase
    end
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            so_st_q <= SO_IDLE;
            so_sh_q <= '0;
            so_left_q <= 7'h00;
            so_data_q <= 1'b0;
            so_frame_q <= 1'b0;
        end else begin
            so_st_q <= so_st_d;
            so_frame_q <= so_start_w;
            if (so_start_w) begin
                so_data_q <= frame_w[FRM_W-1];
                so_sh_q <= frame_w << 1;
                so_left_q <= bits_w - 7'h01;
            end else if (so_st_q == SO_SHIFT && so_left_q != 7'h00) begin
                so_data_q <= so_sh_q[FRM_W-1];
                so_sh_q <= so_sh_q << 1;
                so_left_q <= so_left_q - 7'h01;
            end else begin
                so_data_q <= 1'b0;
            end
        end
    end

    // no back-pressure, a sample meeting a busy link is dropped and counted
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ovr_q <= 8'h00;
        end else if (out_vld_q && so_st_q == SO_SHIFT && ovr_q != 8'hFF) begin
            ovr_q <= ovr_q + 8'h01;
        end
    end

    // Outputs
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign prdata_o = prdata_q;
    assign vga_atten_o = vga_atten_q;
    assign so_data_o = so_data_q;
    assign so_frame_o = so_frame_q;

    // Checks; helper mirrors the stage one wrap
    logic [4:0] gap1_q;
    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) gap1_q <= 5'h00;
        else if (mix_vld_q) gap1_q <= (gap1_q == STG1_RATIO - 5'h01) ? 5'h00 : gap1_q + 5'h01;
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    mix_carrier_a: assert property (phase_q == 3'h2 |-> cos_w == 8'sh00 && sin_w == 8'sh40
        ##1 phase_q == 3'h3) else $error("carrier phase wrong");
    chain_order_a: assert property (s3_vld_q |-> $past(s2_vld))
        else $error("stage three output without stage two input");
    stg1_ratio_a: assert property (s1_vld |-> $past(gap1_q) == 5'h0B)
        else $error("stage one ratio not twelve");
    stg2_range_a: assert property (dec2_q >= 5'h01 && dec2_q <= 5'h10)
        else $error("stage two ratio out of range");
    stg3_dump_a: assert property ((s2_vld && cnt3_q == last3_w) |=> s3_vld_q && cnt3_q == 3'h0)
        else $error("stage three missed its dump");
    gain_unity_a: assert property ((s3_vld_q && dgain_w == 4'h0) |=> out_vld_q && out_q == $past(s3_q))
        else $error("unity gain altered sample");
    man_gain_a: assert property (!ctrl_q.agc_en |=> vga_atten_q == $past(gain_q[3:0]))
        else $error("manual analog gain not applied");
    agc_clip_a: assert property ((ctrl_q.agc_en && s3_vld_q && clip_q && atten_q < ATTEN_MAX)
        |=> atten_q == $past(atten_q) + 4'h1) else $error("clip did not raise attenuation");
    frame_start_a: assert property (so_start_w |=> so_frame_q && so_st_q == SO_SHIFT
        && so_data_q == $past(frame_w[FRM_W-1])) else $error("frame start wrong");
    frame_full_a: assert property ((so_start_w && ctrl_q.attn_en && ctrl_q.rssi_en
        && !ctrl_q.word16) |=> so_left_q == 7'h5F) else $error("four-word frame length wrong");
    out_pair_a: assert property (out_vld_q |-> $past(s3_vld_q))
        else $error("output pair without decimated sample");
    apb_wait_a: assert property ((psel_i && penable_i && !pready_q) |=> pready_q ##1 !pready_q)
        else $error("APB answer not one cycle");

    agc_move_c: cover property (ctrl_q.agc_en && atten_q != $past(atten_q));
    frame_four_c: cover property (so_start_w && ctrl_q.attn_en && ctrl_q.rssi_en);
    overrun_c: cover property (out_vld_q && so_st_q == SO_SHIFT);
    stg3_five_c: cover property (s3_vld_q && ctrl_q.r3_five);
endmodule : ifd_top

// File: rtl/ifd_pkg.sv
// Constants, types and helpers for the IF decimation, gain and serial output block
package ifd_pkg;
    // Widths
    localparam int MOD_W = 4;
    localparam int SMP_W = 24;
    localparam int CIC_W = 48;
    localparam int CIC_ORDER = 4;
    localparam int FRM_W = 96;
    localparam logic signed [SMP_W-1:0] SMP_MAX = 24'sh7FFFFF;
    localparam logic signed [SMP_W-1:0] SMP_MIN = 24'sh800000;
    // Decimation settings
    localparam logic [4:0] STG1_RATIO = 5'h0C;
    localparam logic [5:0] STG1_SHIFT = 6'h03;
    localparam logic [4:0] STG2_MIN = 5'h01;
    localparam logic [4:0] STG2_MAX = 5'h10;
    localparam logic [2:0] STG3_LAST4 = 3'h3;
    localparam logic [2:0] STG3_LAST5 = 3'h4;
    localparam logic [6:0] STG3_MUL5 = 7'h33;
    localparam int STG3_SHR5 = 8;
    localparam int STG3_SHR4 = 2;
    // Gain limits
    localparam logic [3:0] ATTEN_MAX = 4'hC;
    localparam logic [3:0] ATTEN_STEP = 4'h6;
    localparam logic [3:0] DGAIN_MAX = 4'hF;
    localparam int RSSI_SHR = 4;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DEC2 = 8'h04;
    localparam logic [7:0] ADDR_GAIN = 8'h08;
    localparam logic [7:0] ADDR_REF = 8'h0C;
    localparam logic [7:0] ADDR_STAT = 8'h10;
    localparam logic [7:0] ADDR_RSSI = 8'h14;
    // Field positions
    localparam int GAIN_DIG_LSB = 4;
    localparam int STAT_DG_LSB = 4;
    localparam int STAT_OVR_LSB = 8;
    localparam int STAT_BUSY_BIT = 16;
    // Reset values
    localparam logic [5:0] CTRL_RST = 6'h01;
    localparam logic [4:0] DEC2_RST = 5'h10;
    localparam logic [7:0] GAIN_RST = 8'h00;
    localparam logic [23:0] REF_RST = 24'h010000;
    // Control register, bit 0 at the bottom
    typedef struct packed {
        logic r3_five;
        logic rssi_en;
        logic attn_en;
        logic word16;
        logic agc_en;
        logic run;
    } ifd_ctrl_s;
    typedef struct packed {
        logic signed [SMP_W-1:0] i;
        logic signed [SMP_W-1:0] q;
    } ifd_iq_s;
    typedef enum logic [1:0] {SO_IDLE = 2'b01, SO_SHIFT = 2'b10} ifd_so_e;
    // Carrier table, cosine at clock/8, scaled by 64
    function automatic logic signed [7:0] mix_coef(input logic [2:0] ph);
        case (ph)
            3'h0: return 8'sh40;
            3'h1, 3'h7: return 8'sh2D;
            3'h3, 3'h5: return 8'shD3;
            3'h4: return 8'shC0;
            default: return 8'sh00;
        endcase
    endfunction : mix_coef
    // Comb bit growth, ceil of 4*log2(ratio)
    function automatic logic [5:0] cic_shift(input logic [4:0] r);
        case (r)
            5'h02: return 6'h04;
            5'h03: return 6'h07;
            5'h04: return 6'h08;
            5'h05: return 6'h0A;
            5'h06: return 6'h0B;
            5'h07, 5'h08: return 6'h0C;
            5'h09: return 6'h0D;
            5'h0A, 5'h0B: return 6'h0E;
            5'h0C, 5'h0D: return 6'h0F;
            5'h0E, 5'h0F, 5'h10: return 6'h10;
            default: return 6'h00;
        endcase
    endfunction : cic_shift
    // Left shift with saturation to the sample width
    function automatic logic signed [SMP_W-1:0] sat_shl(input logic signed [SMP_W-1:0] x,
                                                       input logic [3:0] g);
        logic signed [SMP_W+15:0] w;
        w = (SMP_W+16)'(x) <<< g;
        if (w > (SMP_W+16)'(SMP_MAX)) return SMP_MAX;
        if (w < (SMP_W+16)'(SMP_MIN)) return SMP_MIN;
        return SMP_W'(w);
    endfunction : sat_shl
    // Magnitude of a signed sample
    function automatic logic [SMP_W-1:0] mag(input logic signed [SMP_W-1:0] x);
        return x[SMP_W-1] ? SMP_W'(-x) : SMP_W'(x);
    endfunction : mag
endpackage : ifd_pkg

// File: rtl/ifd_cic4.sv
// Fourth-order comb decimator with run-time ratio and output shift
`timescale 1ns/1ps
module ifd_cic4 (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Input stream
    input wire logic in_vld_i,
    input wire logic signed [ifd_pkg::SMP_W-1:0] in_i,
    // Ratio 1 to 16 and output shift
    input wire logic [4:0] ratio_i,
    input wire logic [5:0] shift_i,
    // Decimated output
    output logic out_vld_o,
    output logic signed [ifd_pkg::SMP_W-1:0] out_o
);
    import ifd_pkg::*;

    logic signed [CIC_W-1:0] integ_q [CIC_ORDER];
    logic signed [CIC_W-1:0] dly_q [CIC_ORDER];
    logic signed [CIC_W-1:0] comb_w [CIC_ORDER+1];
    logic [4:0] cnt_q;

    // Dump on the ratio-th input; a ratio cut below the count dumps at once
    wire dump_w = in_vld_i && (cnt_q >= ratio_i - 5'h01);

    // Comb chain, only latched at dump time
    assign comb_w[0] = integ_q[CIC_ORDER-1];
    for (genvar k = 0; k < CIC_ORDER; k++) begin : g_comb
        assign comb_w[k+1] = comb_w[k] - dly_q[k];
    end

    // Integrators wrap freely; the combs undo the wrap
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int k = 0; k < CIC_ORDER; k++) integ_q[k] <= '0;
        end else if (in_vld_i) begin
            integ_q[0] <= integ_q[0] + CIC_W'(in_i);
            for (int k = 1; k < CIC_ORDER; k++) integ_q[k] <= integ_q[k] + integ_q[k-1];
        end
    end

    // Counter, comb delays and scaled output
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 5'h00;
            out_vld_o <= 1'b0;
            out_o <= '0;
            for (int k = 0; k < CIC_ORDER; k++) dly_q[k] <= '0;
        end else begin
            out_vld_o <= dump_w;
            if (in_vld_i) cnt_q <= dump_w ? 5'h00 : cnt_q + 5'h01;
            if (dump_w) begin
                for (int k = 0; k < CIC_ORDER; k++) dly_q[k] <= comb_w[k];
                out_o <= SMP_W'(comb_w[CIC_ORDER] >>> shift_i);
            end
        end
    end

    dump_rate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (in_vld_i && cnt_q == ratio_i - 5'h01) |=> out_vld_o)
        else $error("comb output missing after ratio inputs");
endmodule : ifd_cic4

// File: dv/ifd_dsp_rx.sv
// Receiving processor model: captures each serial output frame
`timescale 1ns/1ps
module ifd_dsp_rx (
    // Clock
    input wire logic clk_i,
    // Serial lines and expected frame shape
    input wire logic so_data_i,
    input wire logic so_frame_i,
    input wire logic word16_i,
    input wire logic [2:0] nwords_i,
    // Captured frame, right-aligned, and frame spacing in clocks
    output logic [95:0] frm_o,
    output logic got_o,
    output int per_o
);
    int n = 0;
    int c = 0;
    int len;
    logic [95:0] sh = '0;
    assign len = int'(nwords_i) * (word16_i ? 16 : 24);
    initial got_o = 1'b0;
    always @(posedge clk_i) begin
        got_o <= 1'b0;
        if (so_frame_i) begin
            n = 0;
            per_o <= c;
            c = 0;
        end
        c++;
        if (so_frame_i || (n > 0 && n < len)) begin
            sh = {sh[94:0], so_data_i};
            n++;
            if (n == len) begin
                frm_o <= sh;
                got_o <= 1'b1;
            end
        end
    end
endmodule : ifd_dsp_rx

// File: dv/if_decimation_gain_output_tb.sv
// Self-checking bench for the IF decimation, gain and serial output block
`timescale 1ns/1ps
module if_decimation_gain_output_tb;
    import ifd_pkg::*;
    logic clk = 0, rst_n = 0, clip = 0, psel = 0, pen = 0, pwr = 0, w16 = 0;
    logic signed [3:0] mod = '0;
    logic [7:0] paddr = '0;
    logic [31:0] pwd = '0, rd;
    logic pready, pslverr, sod, sof, got, e;
    logic [31:0] prdata;
    logic [3:0] atten;
    logic [95:0] frm;
    logic [2:0] nw = 3'h2;
    int per, fails = 0, samples_checked = 0, cyc = 0, amp = 0;
    int mdl[4] = '{1, 16, 0, 'h10000};
    ifd_top DUT (.sys_clk_i(clk), .rst_n_i(rst_n), .mod_data_i(mod), .adc_clip_i(clip),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
        .vga_atten_o(atten), .so_data_o(sod), .so_frame_o(sof));
    ifd_dsp_rx rx (.clk_i(clk), .so_data_i(sod), .so_frame_i(sof), .word16_i(w16),
        .nwords_i(nw), .frm_o(frm), .got_o(got), .per_o(per));
    initial forever #10 clk = ~clk;
    // Tone at the carrier, phase counted from reset release; cut a hang short
    always @(posedge clk) begin
        cyc++;
        case ((cyc - 5) & 7)
            0, 1, 7: mod <= 4'(amp);
            3, 4, 5: mod <= 4'(-amp);
            default: mod <= 4'h0;
        endcase
        if (cyc == 60000) begin
            fails++;
            results();
        end
    end
    task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v, input string m);
        samples_checked++;
        if (got_v !== exp_v) begin
            fails++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got_v, exp_v);
        end
    endtask : chk
    // One APB transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task automatic frames(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            while (got !== 1'b1) @(posedge clk);
        end
    endtask : frames
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    initial begin
        int a, g, x;
        logic [23:0] aw;
        void'($urandom(29917));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(0, 8'(4 * i), '0);
            chk(rd, mdl[i], "reset value");
        end
        apb(0, 8'h18, '0);
        chk({rd[30:0], e}, 32'h1, "unmapped read");
        apb(1, ADDR_DEC2, 32'h0);
        apb(0, ADDR_DEC2, '0);
        chk(rd, 32'h1, "ratio low clamp");
        apb(1, ADDR_DEC2, 32'h11);
        apb(0, ADDR_DEC2, '0);
        chk(rd, 32'h10, "ratio high clamp");
        $display("test registers done");
        w16 <= 1'b1;
        foreach (mdl[r]) for (int f = 0; f < 2; f++) begin
            x = (r == 0) ? 1 : r * 5;
            apb(1, ADDR_DEC2, 32'(x));
            apb(1, ADDR_CTRL, 32'h5 | (32'(f) << 5));
            frames(3);
            chk(per, 12 * x * (4 + f), "output period");
            chk(frm[31:0], 32'h0, "zero input gives zero I Q");
        end
        $display("test decimation done");
        apb(1, ADDR_DEC2, 32'h4);
        nw <= 3'h4;
        repeat (4) begin
            a = $urandom_range(0, 12);
            g = $urandom_range(0, 15);
            w16 <= 1'($urandom);
            apb(1, ADDR_GAIN, 32'((g << 4) | a));
            apb(1, ADDR_CTRL, 32'h19 | (32'(w16) << 2));
            frames(2);
            aw = {4'(a), 4'(g), 16'h0};
            chk(32'(atten), 32'(a), "manual atten");
            x = w16 ? 16 : 24;
            chk(32'(frm >> x) & ((32'h1 << x) - 1), w16 ? aw[23:8] : aw, "attn word");
            chk(32'(frm) & ((32'h1 << x) - 1), 32'h0, "rssi word");
        end
        $display("test manual gain done");
        nw <= 3'h2;
        w16 <= 1'b1;
        apb(1, ADDR_DEC2, 32'h1);
        clip <= 1'b1;
        apb(1, ADDR_CTRL, 32'h7);
        frames(20);
        chk(32'(atten), 32'(ATTEN_MAX), "clip drives atten up");
        clip <= 1'b0;
        apb(1, ADDR_REF, 32'hFFFFFF);
        frames(20);
        chk(32'(atten), 32'h0, "low level drives atten down");
        $display("test automatic gain done");
        nw <= 3'h2;
        w16 <= 1'b0;
        repeat (2) begin
            amp = $urandom_range(1, 7);
            g = $urandom_range(0, 7);
            apb(1, ADDR_GAIN, 32'(g << 4));
            apb(1, ADDR_CTRL, 32'h1);
            frames(6);
            // I per sample repeats 64,45,0,45 times amp; the combs keep only the mean
            x = ((154 * amp * (int'(STG1_RATIO) ** 4) / 4) >>> STG1_SHIFT) << g;
            x = (x > int'(SMP_MAX)) ? int'(SMP_MAX) : x;
            chk(32'(frm[47:24]), 32'(x), "tone in-phase level");
            chk(32'(frm[23:0]), 32'h0, "tone quadrature level");
        end
        $display("test carrier tone done");
        results();
    end
endmodule : if_decimation_gain_output_tb
